// ---- logic/wff_mem.sv ----
// Single port memory with registered read data
`timescale 1ns/1ps
module wff_mem #(
  parameter int W = 32,
  parameter int AW = 7
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_we,
  input wire logic [AW-1:0] i_addr,
  input wire logic [W-1:0] i_wdata,
  output logic [W-1:0] o_rdata
);

  logic [W-1:0] mem [2**AW];
  logic [W-1:0] rdata_q;

  always_ff @(posedge i_clk_sys) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= mem[i_addr];
    end
  end

  assign o_rdata = rdata_q;

endmodule // wff_mem

// ---- logic/wff_pkg.sv ----
// Constants, carriers and helpers for the wake frame and address filter
package wff_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_FILT = 32;
  localparam int MASK_BITS = 128;
  localparam int NUM_ENTRY = 33;
  localparam int MASK_AW = 7;
  localparam int FRAME_AW = 9;
  localparam int ADDR_W = 12;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [11:0] CFG_BASE = 12'h150;
  localparam logic [11:0] CFG_LAST = 12'h1cc;
  localparam logic [11:0] MASK_BASE = 12'h200;
  localparam logic [11:0] MASK_LAST = 12'h3fc;
  localparam logic [11:0] ENT_BASE = 12'h400;
  localparam logic [11:0] ENT_LAST = 12'h504;
  localparam logic [11:0] STAT_ADDR = 12'h508;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CFG_EN_BIT = 31;
  localparam int CFG_TYPE_LO = 24;
  localparam int CFG_OFS_LO = 16;
  localparam logic [31:0] CFG_RW_MASK = 32'h83ff_ffff;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam int ENT_VALID_BIT = 31;
  localparam int ENT_SRC_BIT = 30;
  localparam logic [31:0] ENT_RW_MASK = 32'hc000_ffff;
  localparam int STAT_FLAG_BIT = 8;
  localparam logic [6:0] INIT_ALL = 7'h7f;
  localparam logic [6:0] INIT_F0 = 7'h03;
  localparam logic [9:0] FRAME_CAP = 10'h200;
  localparam logic [13:0] CNT_SAT = 14'h3fff;
  localparam logic [13:0] MIN_ADDR_LEN = 14'h00b;

  // ****************************************
  // CRC-16 (reflected 8005h, preset ffffh)
  // ****************************************
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [15:0] CRC_INIT = 16'hffff;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic valid;
    logic last;
    logic err;
    logic [7:0] data;
  } wff_rx_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } wff_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } wff_apb_rsp_t;

  function automatic logic [15:0] wff_crc16_byte(input logic [15:0] c,
                                                 input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

endpackage

// ---- logic/wff_top.sv ----
// Wake frame filters and exact address table behind an APB slave
`timescale 1ns/1ps
module wff_top (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire wff_pkg::wff_apb_req_t i_apb,
  output wff_pkg::wff_apb_rsp_t o_apb,
  input wire wff_pkg::wff_rx_t i_rx,
  input wire logic i_usb_reset,
  input wire logic i_lite_soft_reset,
  input wire logic i_img_load,
  input wire logic [31:0] i_img_cfg0,
  input wire logic [127:0] i_img_mask0,
  output logic o_wake_hit,
  output logic o_wake_frame_seen_flag,
  output logic [4:0] o_matching_filter_index,
  output logic o_addr_hit,
  output logic [5:0] o_addr_index,
  output logic o_scan_busy
);
  import wff_pkg::*;

  typedef enum logic [2:0] {
    SC_IDLE, SC_FILT, SC_ADDR, SC_BYTE, SC_CMP
  } wff_scan_t;

  // ****************************************
  // State
  // ****************************************
  logic [31:0] cfg_q [NUM_FILT];
  logic [31:0] cfg_d [NUM_FILT];
  logic [31:0] ent_hi_q [NUM_ENTRY];
  logic [31:0] ent_hi_d [NUM_ENTRY];
  logic [31:0] ent_lo_q [NUM_ENTRY];
  logic [31:0] ent_lo_d [NUM_ENTRY];
  logic flag_q, flag_d;
  logic [4:0] index_q, index_d;
  logic pend_q, pend_d;
  wff_apb_rsp_t rsp_q, rsp_d;
  logic init_q, init_d;
  logic [6:0] icnt_q, icnt_d;
  logic [6:0] ilast_q, ilast_d;
  logic [13:0] bcnt_q, bcnt_d;
  logic [47:0] da_q, da_d;
  logic [47:0] sa_q, sa_d;
  logic cap_q, cap_d;
  logic mcast_q, mcast_d;
  logic [9:0] flen_q, flen_d;
  logic scan_go;
  logic ahit_q, ahit_d;
  logic [5:0] aidx_q, aidx_d;
  wff_scan_t st_q, st_d;
  logic [4:0] fidx_q, fidx_d;
  logic [6:0] j_q, j_d;
  logic [15:0] crc_q, crc_d;
  logic fail_q, fail_d;
  logic whit_q, whit_d;
  logic busy_q;

  // ****************************************
  // Memories
  // ****************************************
  logic m_we;
  logic [MASK_AW-1:0] m_addr;
  logic [31:0] m_wdata, m_rdata;
  logic f_we;
  logic [FRAME_AW-1:0] f_addr, scan_pos;
  logic [7:0] f_rdata;

  wff_mem #(.W(32), .AW(MASK_AW)) u_mask (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_we(m_we),
    .i_addr(m_addr),
    .i_wdata(m_wdata),
    .o_rdata(m_rdata)
  );

  wff_mem #(.W(8), .AW(FRAME_AW)) u_frame (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_we(f_we),
    .i_addr(f_addr),
    .i_wdata(i_rx.data),
    .o_rdata(f_rdata)
  );

  // ****************************************
  // APB decode
  // ****************************************
  logic acc, first, sel_cfg, sel_mask, sel_ent, sel_stat, mask_free;
  logic [4:0] cfg_idx;
  logic [5:0] ent_idx;
  logic [11:0] ent_off;
  logic apb_mw;

  always_comb begin
    acc = i_apb.psel & i_apb.penable;
    first = acc & !pend_q & !rsp_q.pready;
    sel_cfg = i_apb.paddr >= CFG_BASE && i_apb.paddr <= CFG_LAST;
    sel_mask = i_apb.paddr >= MASK_BASE && i_apb.paddr <= MASK_LAST;
    sel_ent = i_apb.paddr >= ENT_BASE && i_apb.paddr <= ENT_LAST;
    sel_stat = i_apb.paddr == STAT_ADDR;
    if (i_apb.paddr[1:0] != 2'b00) begin
      {sel_cfg, sel_mask, sel_ent, sel_stat} = 4'h0;
    end
    cfg_idx = 5'((i_apb.paddr - CFG_BASE) >> 2);
    ent_off = i_apb.paddr - ENT_BASE;
    ent_idx = 6'(ent_off >> 3);
    mask_free = !init_q && st_q == SC_IDLE;
    apb_mw = first & sel_mask & i_apb.pwrite & mask_free;
  end

  // ****************************************
  // Mask port and image restore
  // ****************************************
  always_comb begin
    init_d = init_q;
    icnt_d = icnt_q;
    ilast_d = ilast_q;
    if (init_q) begin
      icnt_d = icnt_q + 7'h01;
      if (icnt_q == ilast_q) begin
        init_d = 1'b0;
      end
    end
    if (i_usb_reset | i_lite_soft_reset | i_img_load) begin
      init_d = 1'b1;
      icnt_d = '0;
      ilast_d = init_q ? INIT_ALL : INIT_F0;
    end
    m_we = init_q | apb_mw;
    m_wdata = i_apb.pwdata;
    m_addr = i_apb.paddr[8:2];
    if (init_q) begin
      m_addr = icnt_q;
      m_wdata = (icnt_q <= INIT_F0) ? i_img_mask0[icnt_q[1:0]*32 +: 32]
                                    : 32'h0000_0000;
    end else if (st_q != SC_IDLE) begin
      m_addr = {fidx_q, j_q[6:5]};
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      init_q <= 1'b1;
      icnt_q <= '0;
      ilast_q <= INIT_ALL;
    end else begin
      init_q <= init_d;
      icnt_q <= icnt_d;
      ilast_q <= ilast_d;
    end
  end

  // ****************************************
  // Register file and APB answer
  // ****************************************
  always_comb begin
    cfg_d = cfg_q;
    ent_hi_d = ent_hi_q;
    ent_lo_d = ent_lo_q;
    flag_d = flag_q;
    index_d = index_q;
    pend_d = pend_q;
    rsp_d = rsp_q;
    if (rsp_q.pready) begin
      rsp_d.pready = 1'b0;
      rsp_d.pslverr = 1'b0;
      pend_d = 1'b0;
    end else if (first && (!sel_mask || mask_free)) begin
      pend_d = 1'b1;
      if (i_apb.pwrite) begin
        if (sel_cfg) begin
          cfg_d[cfg_idx] = i_apb.pwdata & CFG_RW_MASK;
        end
        if (sel_ent && !ent_off[2]) begin
          ent_hi_d[ent_idx] = i_apb.pwdata & ENT_RW_MASK;
        end
        if (sel_ent && ent_off[2]) begin
          ent_lo_d[ent_idx] = i_apb.pwdata;
        end
        if (sel_stat && i_apb.pwdata[STAT_FLAG_BIT]) begin
          flag_d = 1'b0;
        end
      end
    end else if (acc && pend_q) begin
      rsp_d.pready = 1'b1;
      rsp_d.pslverr = !(sel_cfg | sel_mask | sel_ent | sel_stat);
      rsp_d.prdata = '0;
      if (!i_apb.pwrite) begin
        if (sel_cfg) begin
          rsp_d.prdata = cfg_q[cfg_idx];
        end
        if (sel_mask) begin
          rsp_d.prdata = m_rdata;
        end
        if (sel_ent) begin
          rsp_d.prdata = ent_off[2] ? ent_lo_q[ent_idx] : ent_hi_q[ent_idx];
        end
        if (sel_stat) begin
          rsp_d.prdata = {23'h0, flag_q, 3'h0, index_q};
        end
      end
    end
    if (init_q && icnt_q == 7'h00) begin
      cfg_d[0] = i_img_cfg0 & CFG_RW_MASK;
    end
    if (whit_d) begin
      flag_d = 1'b1;
      index_d = fidx_q;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < NUM_FILT; i++) begin
        cfg_q[i] <= CFG_RESET;
      end
      for (int i = 0; i < NUM_ENTRY; i++) begin
        ent_hi_q[i] <= '0;
        ent_lo_q[i] <= '0;
      end
      flag_q <= 1'b0;
      index_q <= '0;
      pend_q <= 1'b0;
      rsp_q <= '0;
    end else begin
      cfg_q <= cfg_d;
      ent_hi_q <= ent_hi_d;
      ent_lo_q <= ent_lo_d;
      flag_q <= flag_d;
      index_q <= index_d;
      pend_q <= pend_d;
      rsp_q <= rsp_d;
    end
  end

  // ****************************************
  // Receive capture and exact address match
  // ****************************************
  always_comb begin
    bcnt_d = bcnt_q;
    da_d = da_q;
    sa_d = sa_q;
    cap_d = cap_q;
    mcast_d = mcast_q;
    flen_d = flen_q;
    ahit_d = 1'b0;
    aidx_d = aidx_q;
    scan_go = 1'b0;
    if (i_rx.valid) begin
      if (bcnt_q == 14'h0) begin
        cap_d = st_q == SC_IDLE;
        mcast_d = (st_q == SC_IDLE) ? i_rx.data[0] : mcast_q;
      end
      if (bcnt_q < 14'h6) begin
        da_d[bcnt_q[2:0]*8 +: 8] = i_rx.data;
      end else if (bcnt_q < 14'hc) begin
        sa_d[3'(bcnt_q - 14'h6)*8 +: 8] = i_rx.data;
      end
      bcnt_d = (bcnt_q == CNT_SAT) ? bcnt_q : bcnt_q + 14'h1;
      if (i_rx.last) begin
        bcnt_d = '0;
        if (cap_d) begin
          flen_d = (bcnt_q >= 14'h1ff) ? FRAME_CAP : 10'(bcnt_q + 14'h1);
        end
        scan_go = cap_d & !i_rx.err;
        if (!i_rx.err && bcnt_q >= MIN_ADDR_LEN) begin
          for (int e = NUM_ENTRY - 1; e >= 0; e--) begin
            if (ent_hi_q[e][ENT_VALID_BIT] &&
                (ent_hi_q[e][ENT_SRC_BIT] ? sa_d : da_d) ==
                {ent_hi_q[e][15:0], ent_lo_q[e]}) begin
              ahit_d = 1'b1;
              aidx_d = 6'(e);
            end
          end
        end
      end
    end
    f_we = i_rx.valid & cap_d & (bcnt_q < 14'h200);
    f_addr = (st_q == SC_IDLE) ? bcnt_q[8:0] : scan_pos;
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      bcnt_q <= '0;
      da_q <= '0;
      sa_q <= '0;
      cap_q <= 1'b0;
      mcast_q <= 1'b0;
      flen_q <= '0;
      ahit_q <= 1'b0;
      aidx_q <= '0;
    end else begin
      bcnt_q <= bcnt_d;
      da_q <= da_d;
      sa_q <= sa_d;
      cap_q <= cap_d;
      mcast_q <= mcast_d;
      flen_q <= flen_d;
      ahit_q <= ahit_d;
      aidx_q <= aidx_d;
    end
  end

  // ****************************************
  // Wake filter scan
  // ****************************************
  logic [31:0] cur_cfg;

  always_comb begin
    cur_cfg = cfg_q[fidx_q];
    scan_pos = 9'(cur_cfg[CFG_OFS_LO +: 8]) + 9'(j_q);
    st_d = st_q;
    fidx_d = fidx_q;
    j_d = j_q;
    crc_d = crc_q;
    fail_d = fail_q;
    whit_d = 1'b0;
    case (st_q)
      SC_IDLE: begin
        if (scan_go) begin
          fidx_d = '0;
          st_d = SC_FILT;
        end
      end
      SC_FILT: begin
        if (cur_cfg[CFG_EN_BIT] &&
            (cur_cfg[CFG_TYPE_LO] ||
             cur_cfg[CFG_TYPE_LO + 1] == mcast_q)) begin
          crc_d = CRC_INIT;
          j_d = '0;
          fail_d = 1'b0;
          st_d = SC_ADDR;
        end else if (fidx_q == 5'(NUM_FILT - 1)) begin
          st_d = SC_IDLE;
        end else begin
          fidx_d = fidx_q + 5'h01;
        end
      end
      SC_ADDR: begin
        if (!init_q) begin
          st_d = SC_BYTE;
        end
      end
      SC_BYTE: begin
        if (m_rdata[j_q[4:0]]) begin
          if ({1'b0, scan_pos} >= flen_q) begin
            fail_d = 1'b1;
          end else begin
            crc_d = wff_crc16_byte(crc_q, f_rdata);
          end
        end
        j_d = j_q + 7'h01;
        st_d = (j_q == 7'(MASK_BITS - 1)) ? SC_CMP : SC_ADDR;
      end
      SC_CMP: begin
        if (!fail_q && crc_q == cur_cfg[15:0]) begin
          whit_d = 1'b1;
          st_d = SC_IDLE;
        end else if (fidx_q == 5'(NUM_FILT - 1)) begin
          st_d = SC_IDLE;
        end else begin
          fidx_d = fidx_q + 5'h01;
          st_d = SC_FILT;
        end
      end
      default: begin
        st_d = SC_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= SC_IDLE;
      fidx_q <= '0;
      j_q <= '0;
      crc_q <= CRC_INIT;
      fail_q <= 1'b0;
      whit_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      fidx_q <= fidx_d;
      j_q <= j_d;
      crc_q <= crc_d;
      fail_q <= fail_d;
      whit_q <= whit_d;
      busy_q <= st_d != SC_IDLE;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign o_apb = rsp_q;
  assign o_wake_hit = whit_q;
  assign o_wake_frame_seen_flag = flag_q;
  assign o_matching_filter_index = index_q;
  assign o_addr_hit = ahit_q;
  assign o_addr_index = aidx_q;
  assign o_scan_busy = busy_q;

endmodule // wff_top

// ---- tb/wff_chk.sv ----
// Port assertions for the wake frame and address filter
`timescale 1ns/1ps
module wff_chk (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire wff_pkg::wff_apb_req_t i_apb,
  input wire wff_pkg::wff_apb_rsp_t o_apb,
  input wire wff_pkg::wff_rx_t i_rx,
  input wire logic o_wake_hit,
  input wire logic o_wake_frame_seen_flag,
  input wire logic [4:0] o_matching_filter_index,
  input wire logic o_addr_hit,
  input wire logic [5:0] o_addr_index,
  input wire logic o_scan_busy
);
  import wff_pkg::*;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  AST_READY_PULSE: assert property (
    o_apb.pready |=> !o_apb.pready) else $error("ready too long");
  AST_CFG_LATENCY: assert property (
    $rose(i_apb.psel && i_apb.penable) && i_apb.paddr >= CFG_BASE &&
    i_apb.paddr <= CFG_LAST |-> !o_apb.pready ##1 !o_apb.pready
    ##1 o_apb.pready) else $error("config answer late");
  AST_UNMAPPED: assert property (
    o_apb.pready && i_apb.paddr > STAT_ADDR |-> o_apb.pslverr &&
    (i_apb.pwrite || o_apb.prdata == 32'h0)) else $error("no slave error");
  AST_ADDR_CAUSE: assert property (
    o_addr_hit |-> $past(i_rx.valid && i_rx.last && !i_rx.err))
    else $error("address hit without frame end");
  AST_ADDR_RANGE: assert property (
    o_addr_hit |-> o_addr_index <= 6'h20) else $error("entry out of range");
  AST_SCAN_START: assert property (
    $rose(o_scan_busy) |-> $past(i_rx.valid && i_rx.last && !i_rx.err))
    else $error("scan without good frame");
  AST_HIT_IN_SCAN: assert property (
    o_wake_hit |-> $past(o_scan_busy)) else $error("hit outside scan");
  AST_FLAG_SET: assert property (
    o_wake_hit |-> o_wake_frame_seen_flag) else $error("flag not set");
  AST_INDEX_HOLD: assert property (
    !o_wake_hit |-> $stable(o_matching_filter_index))
    else $error("index moved");
  AST_FLAG_CLEAR: assert property (
    $fell(o_wake_frame_seen_flag) |-> $past(i_apb.psel && i_apb.pwrite
    && i_apb.paddr == STAT_ADDR && i_apb.pwdata[STAT_FLAG_BIT]))
    else $error("flag dropped");
endmodule // wff_chk

bind wff_top wff_chk u_chk (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
  .i_apb(i_apb), .o_apb(o_apb), .i_rx(i_rx), .o_wake_hit(o_wake_hit),
  .o_wake_frame_seen_flag(o_wake_frame_seen_flag),
  .o_matching_filter_index(o_matching_filter_index),
  .o_addr_hit(o_addr_hit), .o_addr_index(o_addr_index),
  .o_scan_busy(o_scan_busy));

// ---- tb/wff_rx_src.sv ----
// Receive datapath model sending frames byte by byte
`timescale 1ns/1ps
module wff_rx_src (
  input wire logic i_clk_sys,
  output wff_pkg::wff_rx_t o_rx
);
  import wff_pkg::*;
  logic [7:0] last_byte;
  initial o_rx = '0;
  task automatic send(input logic [7:0] q[$], input logic err);
    for (int i = 0; i < q.size(); i++) begin
      @(posedge i_clk_sys);
      o_rx <= '{1'b1, i == q.size() - 1, err, q[i]};
      last_byte = q[i];
    end
    @(posedge i_clk_sys);
    // Idle byte must not look like a held value
    o_rx <= '{1'b0, 1'b0, 1'b0, ~last_byte};
  endtask
endmodule // wff_rx_src

// ---- tb/wff_top_tb.sv ----
// Self-checking bench for the wake frame and address filter
`timescale 1ns/1ps
module wff_top_tb;
  import wff_pkg::*;
  logic clk, nrst, re, wake_hit, flag, addr_hit, busy;
  logic [2:0] trig;
  logic [4:0] fidx;
  logic [5:0] aidx;
  logic [31:0] img_cfg, rd, w_got, a_got, m_stat;
  logic [127:0] img_mask;
  wff_apb_req_t req;
  wff_apb_rsp_t rsp;
  wff_rx_t rx;
  logic [31:0] m_cfg[32], m_eh[33], m_el[33];
  logic [127:0] m_mask[32];
  int n_fail, cmp_count, seed = 32'h06e89f95;
  wff_top dut (.i_clk_sys(clk), .i_nrst(nrst), .i_apb(req), .o_apb(rsp),
    .i_rx(rx), .i_usb_reset(trig[0]), .i_lite_soft_reset(trig[1]),
    .i_img_load(trig[2]), .i_img_cfg0(img_cfg), .i_img_mask0(img_mask),
    .o_wake_hit(wake_hit), .o_wake_frame_seen_flag(flag),
    .o_matching_filter_index(fidx), .o_addr_hit(addr_hit),
    .o_addr_index(aidx), .o_scan_busy(busy));
  wff_rx_src src (.i_clk_sys(clk), .o_rx(rx));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (wake_hit === 1'b1) w_got <= {27'h0, fidx};
    if (addr_hit === 1'b1) a_got <= {26'h0, aidx};
  end
  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic print_verdict();
    $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic guard(input int n);
    if (n >= 20000) begin
      chk("timeout", 32'h1, 32'h0);
      print_verdict();
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20000);
    guard(n);
    rd = rsp.prdata;
    re = rsp.pslverr;
    req <= '0;
  endtask
  // ****************************************
  // Reference model
  // ****************************************
  function automatic logic [15:0] crc_of(input logic [7:0] q[$],
                                         input int ofs, logic [127:0] m);
    logic [15:0] c;
    c = 16'hffff;
    for (int j = 0; j < 128; j++)
      if (m[j]) begin
        c = c ^ {8'h00, q[ofs + j]};
        repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
      end
    return c;
  endfunction
  function automatic int wake_exp(input logic [7:0] q[$]);
    for (int f = 0; f < 32; f++)
      if (m_cfg[f][31] && (m_cfg[f][24] || m_cfg[f][25] == q[0][0]) &&
          crc_of(q, m_cfg[f][23:16], m_mask[f]) == m_cfg[f][15:0])
        return f;
    return -1;
  endfunction
  function automatic int addr_exp(input logic [7:0] q[$]);
    logic [47:0] da, sa;
    da = {q[5], q[4], q[3], q[2], q[1], q[0]};
    sa = {q[11], q[10], q[9], q[8], q[7], q[6]};
    for (int e = 0; e < 33; e++)
      if (m_eh[e][31] && {m_eh[e][15:0], m_el[e]} == (m_eh[e][30] ? sa : da))
        return e;
    return -1;
  endfunction
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0] q[$];
    logic [127:0] mk;
    logic [47:0] ad;
    int f, e, ofs, widx;
    logic [11:0] ta[5];
    logic [31:0] tx[5];
    req = '0;
    ta = '{12'h1cc, 12'h500, 12'h504, 12'h50c, 12'h152};
    tx = '{32'h83ff_ffff, 32'hc000_ffff, 32'hffff_ffff, 32'h0, 32'h0};
    trig = '0;
    nrst = 1'b0;
    m_stat = '0;
    img_cfg = 32'hfd00_5a5a;
    img_mask = {$random(seed), $random(seed), $random(seed), $random(seed)};
    m_cfg = '{default: '0};
    m_mask = '{default: '0};
    m_eh = '{default: '0};
    m_el = '{default: '0};
    m_cfg[0] = img_cfg & 32'h83ff_ffff;
    m_mask[0] = img_mask;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, 12'(512 + 4 * k), 32'h0);
      chk("mask0 word", rd, img_mask[32*k +: 32]);
    end
    apb(1'b0, 12'h150, 32'h0);
    chk("cfg0 image", rd, m_cfg[0]);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, ta[i], 32'hffff_ffff);
      apb(1'b0, ta[i], 32'h0);
      chk("field access", rd, tx[i]);
      chk("slave error", {31'h0, re}, {31'h0, i > 2});
      apb(1'b1, ta[i], 32'h0);
    end
    $display("register test done");
    for (int t = 0; t < 3; t++) begin
      apb(1'b1, 12'h150, 32'h0);
      apb(1'b1, 12'h20c, 32'h0);
      trig <= 3'(1 << t);
      @(posedge clk);
      trig <= 3'h0;
      apb(1'b0, 12'h20c, 32'h0);
      chk("mask0 restore", rd, img_mask[127:96]);
      apb(1'b0, 12'h150, 32'h0);
      chk("cfg0 restore", rd, m_cfg[0]);
    end
    $display("restore test done");
    for (int k = 0; k < 6; k++) begin
      q = {};
      repeat (160) q.push_back(8'($random(seed)));
      q[0][0] = (k < 4) ? k[1] : (k == 5);
      f = 1 + {$random(seed)} % 31;
      ofs = {$random(seed)} % 32;
      mk = {64'h0, $random(seed), $random(seed)};
      m_mask[f] = mk;
      for (int w = 0; w < 4; w++)
        apb(1'b1, 12'(512 + 16 * f + 4 * w), mk[32*w +: 32]);
      m_cfg[f] = {k != 4, 5'h0, (k < 4) ? 2'(k) : 2'h0, 8'(ofs),
                  crc_of(q, ofs, mk)};
      apb(1'b1, 12'(336 + 4 * f), m_cfg[f]);
      e = {$random(seed)} % 33;
      m_eh[e][30] = k[0];
      for (int b = 0; b < 6; b++)
        ad[8*b +: 8] = q[b + (m_eh[e][30] ? 6 : 0)];
      m_eh[e] = {1'b0, m_eh[e][30], 14'h0, ad[47:32]};
      m_el[e] = ad[31:0];
      apb(1'b1, 12'(1024 + 8 * e), m_eh[e]);
      apb(1'b1, 12'(1028 + 8 * e), m_el[e]);
      m_eh[e][31] = 1'b1;
      apb(1'b1, 12'(1024 + 8 * e), m_eh[e]);
      w_got = '1;
      a_got = '1;
      src.send(q, k == 3);
      repeat (2) @(posedge clk);
      for (int n = 0; n <= 20000; n++) begin
        guard(n);
        if (busy === 1'b0) break;
        @(posedge clk);
      end
      // Let the hit capture settle
      @(posedge clk);
      widx = (k == 3) ? -1 : wake_exp(q);
      chk("wake index", w_got, widx);
      chk("addr index", a_got, (k == 3) ? -1 : addr_exp(q));
      if (widx >= 0) m_stat = {23'h0, 1'b1, 3'h0, 5'(widx)};
      $display("frame test %0d done", k);
    end
    apb(1'b0, 12'h508, 32'h0);
    chk("status", rd, m_stat);
    apb(1'b1, 12'h508, 32'h100);
    apb(1'b0, 12'h508, 32'h0);
    chk("status clear", rd, m_stat & 32'h1f);
    $display("status test done");
    print_verdict();
  end
endmodule // wff_top_tb
